// File: rtl/mra_pkg.sv
`default_nettype none
package mra_pkg;
  // Clock and timebase
  localparam int CLK_HZ       = 25_000_000;
  localparam int TICK_US      = 10;
  localparam int TICK_CYC     = TICK_US * (CLK_HZ / 1_000_000);
  localparam int DIV_W        = 8;
  localparam int CNT_W        = 12;

  // Reset delay, in timebase periods
  localparam logic [CNT_W-1:0] RST_DLY_MIN = 12'h014;
  localparam logic [CNT_W-1:0] RST_DLY_MAX = 12'h7D0;
  localparam logic [CNT_W-1:0] RST_DLY_DEF = 12'h064;

  // Alert line timing
  localparam int ALERT_MIN_LOW_US  = 100;
  localparam int ALERT_MIN_HIGH_US = 300;
  localparam int ALERT_TIMEOUT_US  = 300;
  localparam logic [CNT_W-1:0] ALERT_MIN_LOW_TICKS  = CNT_W'(ALERT_MIN_LOW_US / TICK_US);
  localparam logic [CNT_W-1:0] ALERT_MIN_HIGH_TICKS = CNT_W'(ALERT_MIN_HIGH_US / TICK_US);
  localparam logic [CNT_W-1:0] ALERT_TIMEOUT_TICKS  = CNT_W'(ALERT_TIMEOUT_US / TICK_US);

  // Register map, byte offsets
  localparam int ADDR_W = 5;
  localparam logic [ADDR_W-1:0] OFS_CTRL   = 5'h00;
  localparam logic [ADDR_W-1:0] OFS_STATE  = 5'h04;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 5'h08;
  localparam logic [ADDR_W-1:0] OFS_CLEAR  = 5'h0C;
  localparam logic [ADDR_W-1:0] OFS_ENABLE = 5'h10;

  // State register fields
  localparam int ST_RST_BIT   = 0;
  localparam int ST_RAIL_BIT  = 1;
  localparam int ST_ALERT_BIT = 2;
  localparam int ST_CAUSE_LSB = 4;

  typedef enum logic [1:0] {
    MRA_ALERT_HIGH,
    MRA_ALERT_LOW,
    MRA_ALERT_GUARD
  } mra_alert_state_t;
endpackage
`default_nettype wire

// File: rtl/mra_cnt_if.sv
`timescale 1ns/1ps
`default_nettype none
interface mra_cnt_if #(parameter int W = 12);
  logic         clr;
  logic         tick;
  logic [W-1:0] count;
  modport owner   (output clr, output tick, input count);
  modport counter (input clr, input tick, output count);
endinterface
`default_nettype wire

// File: rtl/mra_tick_counter.sv
`timescale 1ns/1ps
`default_nettype none
module mra_tick_counter import mra_pkg::*; #(
  parameter int W = CNT_W
) (
  input  wire logic   ref_clk_in,
  input  wire logic   reset_n_in,
  mra_cnt_if.counter  cnt
);
  // Saturating count of timebase ticks, restarted by clr
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      cnt.count <= '0;
    end else if (cnt.clr) begin
      cnt.count <= '0;
    end else if (cnt.tick && (cnt.count != {W{1'b1}})) begin
      cnt.count <= cnt.count + W'(1);
    end
  end
endmodule // mra_tick_counter
`default_nettype wire

// File: rtl/mra_top.sv
// Functional notes
// - Reset output goes low as soon as any reset cause appears.
// - Reset released only after all causes clear and full delay elapses.
// - A supply rail out of its band is a reset cause.
// - Hard reset holds reset low and switches host rails off.
// - Soft reset holds reset low with rails kept running.
// - Delay settable 20 to 2000 periods of a 10 us timebase.
// - Delay setting is 100 periods after device reset.
// - Alert line goes low when a new interrupt flag is set.
// - Alert line returns high once software clears all flags.
// - Alert stays low at least the minimum low time.
// - Alert stays high the minimum high time; new alerts wait for it.
// - Alert low time-out releases line and sets missed flag, no new alert.
// - Minimum alert low time is nominally 100 us.
// - Minimum alert high time is nominally 300 us.
// - Alert time-out is nominally 300 us, only while reset released.
//
// The implementer's own choices: the Avalon-MM interface to the registers and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module mra_top import mra_pkg::*; #(
  parameter int N_FLAGS = 8
) (
  input  wire logic               ref_clk_in,
  input  wire logic               reset_n_in,
  input  wire logic [ADDR_W-1:0]  avs_address_in,
  input  wire logic               avs_read_in,
  input  wire logic               avs_write_in,
  input  wire logic [31:0]        avs_writedata_in,
  output logic      [31:0]        avs_readdata_out,
  output logic                    avs_waitrequest_out,
  input  wire logic               soft_req_in,
  input  wire logic               hard_req_in,
  input  wire logic               rail_fault_in,
  input  wire logic [N_FLAGS-1:0] int_event_in,
  output logic                    mcu_reset_out,
  output logic                    mcu_reset_oe_n_out,
  output logic                    host_io_supply_en_out,
  output logic                    alert_n_out,
  output logic                    irq_out
);
  localparam int NIN  = N_FLAGS + 3;
  localparam int NST  = N_FLAGS + 2;

  logic [NIN-1:0]     sync1_reg;
  logic [NIN-1:0]     sync2_reg;
  logic               soft_s;
  logic               hard_s;
  logic               rail_s;
  logic [N_FLAGS-1:0] event_s;
  logic               cause;
  logic [DIV_W-1:0]   div_reg;
  logic               tick_reg;
  logic [CNT_W-1:0]   delay_reg;
  logic               rst_active_reg;
  logic               rst_release;
  logic               rail_en_reg;
  logic [N_FLAGS-1:0] flags_reg;
  logic [N_FLAGS-1:0] flags_next;
  logic               missed_reg;
  logic               missed_set;
  logic               rel_reg;
  logic               new_pend_reg;
  logic [NST-1:0]     enable_reg;
  logic [NST-1:0]     status;
  logic               irq_reg;
  mra_alert_state_t   alert_reg;
  mra_alert_state_t   alert_next;
  logic               alert_n_reg;
  logic               wait_reg;
  logic [31:0]        rdata_reg;
  logic               req;
  logic               wr_ack;
  logic [NST-1:0]     clr_bits;

  mra_cnt_if #(.W(CNT_W)) rd_if ();
  mra_cnt_if #(.W(CNT_W)) al_if ();
  mra_cnt_if #(.W(CNT_W)) to_if ();

  mra_tick_counter #(.W(CNT_W)) u_rd_cnt (
    .ref_clk_in (ref_clk_in),
    .reset_n_in (reset_n_in),
    .cnt        (rd_if)
  );
  mra_tick_counter #(.W(CNT_W)) u_al_cnt (
    .ref_clk_in (ref_clk_in),
    .reset_n_in (reset_n_in),
    .cnt        (al_if)
  );
  mra_tick_counter #(.W(CNT_W)) u_to_cnt (
    .ref_clk_in (ref_clk_in),
    .reset_n_in (reset_n_in),
    .cnt        (to_if)
  );

  // Input synchronisers
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
    end else begin
      sync1_reg <= {rail_fault_in, hard_req_in, soft_req_in, int_event_in};
      sync2_reg <= sync1_reg;
    end
  end

  assign event_s = sync2_reg[N_FLAGS-1:0];
  assign soft_s  = sync2_reg[N_FLAGS];
  assign hard_s  = sync2_reg[N_FLAGS+1];
  assign rail_s  = sync2_reg[N_FLAGS+2];
  assign cause   = soft_s | hard_s | rail_s;

  // Timebase: one tick each 10 us
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      div_reg  <= '0;
      tick_reg <= 1'b0;
    end else if (div_reg == DIV_W'(TICK_CYC - 1)) begin
      div_reg  <= '0;
      tick_reg <= 1'b1;
    end else begin
      div_reg  <= div_reg + DIV_W'(1);
      tick_reg <= 1'b0;
    end
  end

  // Avalon slave handshake
  assign req    = (avs_read_in | avs_write_in) & wait_reg;
  assign wr_ack = avs_write_in & ~wait_reg;

  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      wait_reg <= 1'b1;
    end else begin
      wait_reg <= ~req;
    end
  end

  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rdata_reg <= '0;
    end else if (req && avs_read_in) begin
      if (avs_address_in == OFS_CTRL) begin
        rdata_reg <= 32'(delay_reg);
      end else if (avs_address_in == OFS_STATE) begin
        rdata_reg <= 32'({soft_s, hard_s, rail_s, 1'b0, ~alert_n_reg,
                          rail_en_reg, rst_active_reg});
      end else if (avs_address_in == OFS_STATUS) begin
        rdata_reg <= 32'(status);
      end else if (avs_address_in == OFS_ENABLE) begin
        rdata_reg <= 32'(enable_reg);
      end else begin
        rdata_reg <= '0;
      end
    end
  end

  // Delay setting, clamped to its range
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      delay_reg <= RST_DLY_DEF;
    end else if (wr_ack && avs_address_in == OFS_CTRL) begin
      if (avs_writedata_in[CNT_W-1:0] < RST_DLY_MIN || avs_writedata_in[31:CNT_W] != '0) begin
        delay_reg <= (avs_writedata_in[31:CNT_W] != '0) ? RST_DLY_MAX : RST_DLY_MIN;
      end else if (avs_writedata_in[CNT_W-1:0] > RST_DLY_MAX) begin
        delay_reg <= RST_DLY_MAX;
      end else begin
        delay_reg <= avs_writedata_in[CNT_W-1:0];
      end
    end
  end

  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      enable_reg <= '0;
    end else if (wr_ack && avs_address_in == OFS_ENABLE) begin
      enable_reg <= avs_writedata_in[NST-1:0];
    end
  end

  assign clr_bits = (wr_ack && avs_address_in == OFS_CLEAR) ? avs_writedata_in[NST-1:0] : '0;

  // Reset delay counter restarts while any cause is present
  assign rd_if.clr   = cause;
  assign rd_if.tick  = tick_reg & rst_active_reg;
  assign rst_release = rst_active_reg & ~cause & (rd_if.count > delay_reg);

  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rst_active_reg <= 1'b1;
    end else if (cause) begin
      rst_active_reg <= 1'b1;
    end else if (rst_release) begin
      rst_active_reg <= 1'b0;
    end
  end

  // Host rails off only for a hard reset
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rail_en_reg <= 1'b0;
    end else begin
      rail_en_reg <= ~hard_s;
    end
  end

  // Reset pin: open drain, driven low while oe_n is low
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      mcu_reset_out      <= 1'b0;
      mcu_reset_oe_n_out <= 1'b0;
    end else begin
      mcu_reset_out      <= 1'b0;
      mcu_reset_oe_n_out <= ~(rst_active_reg | cause);
    end
  end

  // Interrupt flags: set wins over clear
  assign flags_next = (flags_reg & ~clr_bits[N_FLAGS-1:0]) | event_s;

  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      flags_reg <= '0;
    end else begin
      flags_reg <= flags_next;
    end
  end

  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      new_pend_reg <= 1'b0;
    end else if (|(event_s & ~flags_reg)) begin
      new_pend_reg <= (alert_reg != MRA_ALERT_HIGH) || (alert_next != MRA_ALERT_LOW);
    end else if (alert_reg == MRA_ALERT_HIGH && alert_next == MRA_ALERT_LOW) begin
      new_pend_reg <= 1'b0;
    end
  end

  // Alert timers
  assign al_if.clr  = (alert_next != alert_reg);
  assign al_if.tick = tick_reg;
  assign to_if.clr  = (alert_next != alert_reg) | rst_active_reg;
  assign to_if.tick = tick_reg;
  assign missed_set = (alert_reg == MRA_ALERT_LOW) && !rst_active_reg
                      && (to_if.count >= ALERT_TIMEOUT_TICKS)
                      && !((al_if.count >= ALERT_MIN_LOW_TICKS) && (flags_reg == '0));

  always_comb begin
    alert_next = alert_reg;
    case (alert_reg)
      MRA_ALERT_HIGH: begin
        if (new_pend_reg || |(event_s & ~flags_reg)) begin
          alert_next = MRA_ALERT_LOW;
        end
      end
      MRA_ALERT_LOW: begin
        if ((al_if.count >= ALERT_MIN_LOW_TICKS) && (flags_reg == '0)) begin
          alert_next = MRA_ALERT_GUARD;
        end else if (missed_set) begin
          alert_next = MRA_ALERT_GUARD;
        end
      end
      MRA_ALERT_GUARD: begin
        if (al_if.count >= ALERT_MIN_HIGH_TICKS) begin
          alert_next = MRA_ALERT_HIGH;
        end
      end
      default: begin
        alert_next = MRA_ALERT_HIGH;
      end
    endcase
  end

  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      alert_reg   <= MRA_ALERT_HIGH;
      alert_n_reg <= 1'b1;
    end else begin
      alert_reg   <= alert_next;
      alert_n_reg <= (alert_next != MRA_ALERT_LOW);
    end
  end

  // Missed flag and reset-release event: sticky, set wins over clear
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      missed_reg <= 1'b0;
      rel_reg    <= 1'b0;
    end else begin
      missed_reg <= missed_set | (missed_reg & ~clr_bits[N_FLAGS]);
      rel_reg    <= rst_release | (rel_reg & ~clr_bits[N_FLAGS+1]);
    end
  end

  assign status = {rel_reg, missed_reg, flags_reg};

  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= |(status & enable_reg);
    end
  end

  assign avs_readdata_out      = rdata_reg;
  assign avs_waitrequest_out   = wait_reg;
  assign host_io_supply_en_out = rail_en_reg;
  assign alert_n_out           = alert_n_reg;
  assign irq_out               = irq_reg;
endmodule // mra_top
`default_nettype wire

// File: sim/mra_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module mra_host_model (
  input  wire logic oe_n_in,
  input  wire logic od_in,
  input  wire logic alert_n_in,
  output logic      rst_pin_out,
  output logic      irq_pin_out
);
  // Open-drain reset pin with pull-up to the host supply
  assign rst_pin_out = oe_n_in ? 1'b1 : od_in;
  // Push-pull alert; the missed flag is polled over the bus
  assign irq_pin_out = !alert_n_in;
endmodule // mra_host_model
`default_nettype wire

// File: sim/mra_top_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module mra_top_monitor import mra_pkg::*; #(
  parameter int N_FLAGS = 8
) (
  input wire logic               ref_clk_in,
  input wire logic               reset_n_in,
  input wire logic [ADDR_W-1:0]  avs_address_in,
  input wire logic               avs_write_in,
  input wire logic [31:0]        avs_writedata_in,
  input wire logic               avs_waitrequest_out,
  input wire logic               soft_req_in,
  input wire logic               hard_req_in,
  input wire logic               rail_fault_in,
  input wire logic [N_FLAGS-1:0] int_event_in,
  input wire logic               mcu_reset_oe_n_out,
  input wire logic               host_io_supply_en_out,
  input wire logic               alert_n_out
);
  logic [19:0] lo_reg;
  logic [19:0] hi_reg;
  logic [19:0] rl_reg;
  logic [19:0] to_reg;
  logic        cz;
  logic [N_FLAGS-1:0] ev1_reg;
  logic [N_FLAGS-1:0] ev2_reg;
  logic [N_FLAGS-1:0] sh_reg;
  logic [N_FLAGS-1:0] clr_m;
  assign cz = soft_req_in | hard_req_in | rail_fault_in;
  // Flag bits cleared by an accepted write to the clear register
  assign clr_m = (avs_write_in && !avs_waitrequest_out && avs_address_in == OFS_CLEAR)
                 ? avs_writedata_in[N_FLAGS-1:0] : '0;
  // Cycles spent low, high, held in reset with no cause, low with reset released
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      lo_reg  <= '0;
      hi_reg  <= 20'd8000;
      rl_reg  <= '0;
      to_reg  <= '0;
      ev1_reg <= '0;
      ev2_reg <= '0;
      sh_reg  <= '0;
    end else begin
      lo_reg  <= alert_n_out ? '0 : lo_reg + 20'd1;
      hi_reg  <= alert_n_out ? hi_reg + 20'd1 : '0;
      rl_reg  <= (cz || mcu_reset_oe_n_out) ? '0 : rl_reg + 20'd1;
      to_reg  <= (alert_n_out || !mcu_reset_oe_n_out) ? '0 : to_reg + 20'd1;
      ev1_reg <= int_event_in;
      ev2_reg <= ev1_reg;
      sh_reg  <= (sh_reg & ~clr_m) | ev2_reg;
    end
  end
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!reset_n_in);
  chk_cause_low: assert property (cz |-> ##[0:4] !mcu_reset_oe_n_out)
    else $error("reset not asserted");
  chk_release_wait: assert property ($rose(mcu_reset_oe_n_out) |-> rl_reg >= 20'd5000)
    else $error("reset released early");
  chk_hard_off: assert property (hard_req_in |-> ##[0:4] !host_io_supply_en_out)
    else $error("rails kept on");
  chk_soft_on: assert property (host_io_supply_en_out && !hard_req_in && !$past(hard_req_in)
    && !$past(hard_req_in, 2) |=> host_io_supply_en_out)
    else $error("rails dropped");
  chk_min_low: assert property ($rose(alert_n_out) |-> lo_reg >= 20'd2250)
    else $error("alert low too short");
  chk_low_timeout: assert property (!alert_n_out && mcu_reset_oe_n_out |-> to_reg <= 20'd7510)
    else $error("alert low too long");
  chk_min_high: assert property ($fell(alert_n_out) |-> hi_reg >= 20'd7250)
    else $error("alert high too short");
  chk_new_alert: assert property (|(ev2_reg & ~sh_reg) && alert_n_out && hi_reg > 20'd7510
    |-> ##[1:3] !alert_n_out) else $error("alert not raised");
endmodule // mra_top_monitor
bind mra_top mra_top_monitor #(.N_FLAGS(N_FLAGS)) u_mon (
  .ref_clk_in(ref_clk_in), .reset_n_in(reset_n_in), .avs_address_in(avs_address_in),
  .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
  .avs_waitrequest_out(avs_waitrequest_out), .soft_req_in(soft_req_in),
  .hard_req_in(hard_req_in), .rail_fault_in(rail_fault_in), .int_event_in(int_event_in),
  .mcu_reset_oe_n_out(mcu_reset_oe_n_out), .host_io_supply_en_out(host_io_supply_en_out),
  .alert_n_out(alert_n_out));
`default_nettype wire

// File: sim/mra_top_bench.sv
`timescale 1ns/1ps
`default_nettype none
module mra_top_bench;
  import mra_pkg::*;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [4:0]  adr = '0;
  logic        rd = 1'b0;
  logic        wr = 1'b0;
  logic [31:0] wd = '0;
  logic [2:0]  cz = '0;
  logic [7:0]  ev = '0;
  logic [31:0] rdat;
  logic        wrq, od, oen, ren, aln, irq, pin, ipin;
  logic [31:0] exq[$];
  int          n_fail = 0;
  int          checks = 0;
  int          n, b;
  always #20 clk = ~clk;
  mra_top dut (.ref_clk_in(clk), .reset_n_in(rst_n), .avs_address_in(adr),
    .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wd), .avs_readdata_out(rdat),
    .avs_waitrequest_out(wrq), .soft_req_in(cz[0]), .hard_req_in(cz[1]),
    .rail_fault_in(cz[2]), .int_event_in(ev), .mcu_reset_out(od),
    .mcu_reset_oe_n_out(oen), .host_io_supply_en_out(ren), .alert_n_out(aln), .irq_out(irq));
  mra_host_model host (.oe_n_in(oen), .od_in(od), .alert_n_in(aln),
    .rst_pin_out(pin), .irq_pin_out(ipin));
  task end_sim;
    if (n_fail == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task chk(input logic c);
    checks++;
    if (c !== 1'b1) begin
      n_fail++;
      $display("MISMATCH %0t pin check", $time);
    end
  endtask
  // Avalon request held until waitrequest is sampled low
  task acc(input logic w, input logic [4:0] a, input logic [31:0] d);
    int i;
    @(posedge clk);
    adr <= a;
    wd <= d;
    wr <= w;
    rd <= !w;
    i = 0;
    do begin
      @(posedge clk);
      i++;
    end while (wrq !== 1'b0 && i < 20);
    wr <= 1'b0;
    rd <= 1'b0;
    if (i >= 20) begin
      n_fail++;
      $display("MISMATCH %0t bus timeout", $time);
      end_sim();
    end
  endtask
  task rr(input logic [4:0] a, input logic [31:0] e);
    exq.push_back(e);
    acc(1'b0, a, '0);
  endtask
  always @(posedge clk) begin
    if (rd && wrq === 1'b0) begin
      checks++;
      if (rdat !== exq.pop_front()) begin
        n_fail++;
        $display("MISMATCH %0t read data", $time);
      end
    end
  end
  task wt(input logic s, input logic v);
    n = 0;
    while ((s ? aln : oen) !== v && n < 40000) begin
      @(posedge clk);
      #1;
      n++;
    end
    if (n >= 40000) begin
      n_fail++;
      $display("MISMATCH %0t wait timeout", $time);
      end_sim();
    end
  endtask
  initial begin
    void'($urandom(4));
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    rr(OFS_CTRL, 32'h00000064);
    rr(OFS_ENABLE, '0);
    rr(OFS_CLEAR, '0);
    rr(5'h14, '0);
    wt(1'b0, 1'b1);
    chk(n > 24700 && n < 25600 && pin === 1'b1);
    rr(OFS_STATE, 32'h00000002);
    acc(1'b1, OFS_CTRL, '0);
    rr(OFS_CTRL, 32'h00000014);
    acc(1'b1, OFS_CTRL, 32'h00000FFF);
    rr(OFS_CTRL, 32'h000007D0);
    acc(1'b1, OFS_CTRL, 32'h00000014);
    for (int k = 0; k < 3; k++) begin
      @(posedge clk);
      cz <= 3'h1 << k;
      wt(1'b0, 1'b0);
      chk(n < 6 && pin === 1'b0);
      repeat (4) @(posedge clk);
      chk(ren === (k != 1));
      cz <= '0;
      wt(1'b0, 1'b1);
      chk(n > 4900 && n < 5600);
    end
    rr(OFS_STATUS, 32'h00000200);
    acc(1'b1, OFS_CLEAR, 32'h00000200);
    acc(1'b1, OFS_ENABLE, 32'h000003FF);
    b = $urandom % 8;
    @(posedge clk);
    ev <= 8'h01 << b;
    wt(1'b1, 1'b0);
    chk(n < 6 && ipin === 1'b1);
    rr(OFS_STATUS, 32'h1 << b);
    @(posedge clk);
    ev <= '0;
    chk(irq === 1'b1);
    acc(1'b1, OFS_CLEAR, 32'h1 << b);
    wt(1'b1, 1'b1);
    chk(n > 2200 && n < 2600);
    rr(OFS_STATUS, '0);
    chk(irq === 1'b0);
    acc(1'b1, OFS_ENABLE, '0);
    @(posedge clk);
    ev <= 8'h01 << b;
    repeat (3) @(posedge clk);
    ev <= '0;
    wt(1'b1, 1'b0);
    chk(n > 6900 && irq === 1'b0);
    wt(1'b1, 1'b1);
    chk(n > 7200 && n < 7600);
    rr(OFS_STATUS, (32'h1 << b) | 32'h00000100);
    repeat (300) @(posedge clk);
    chk(aln === 1'b1);
    acc(1'b1, OFS_CLEAR, 32'h000003FF);
    rr(OFS_STATUS, '0);
    end_sim();
  end
endmodule // mra_top_bench
`default_nettype wire
